// File: pkg/ics_pkg.sv
// constants and types for the interconnect connection service
package ics_pkg;

  // ==========================================================================
  // table and queue geometry
  localparam int unsigned NUM_LOCAL   = 2;   // local interconnect ports
  localparam int unsigned NUM_REMOTE  = 4;   // remote interconnect ports
  localparam int unsigned NUM_CONN    = 4;   // connection table entries
  localparam int unsigned NUM_REQ     = 4;   // upper-layer requesters
  localparam int unsigned MAX_CHARS   = 4;   // characters per send
  localparam int unsigned QUEUE_DEPTH = 16;  // transmit queue characters

  localparam int unsigned LPORT_W = 2;
  localparam int unsigned RPORT_W = 3;
  localparam int unsigned CONN_W  = 2;
  localparam int unsigned REQ_W   = 2;
  localparam int unsigned CNT_W   = 3;
  localparam int unsigned CHAR_W  = 8;
  localparam int unsigned QPTR_W  = 4;
  localparam int unsigned QCNT_W  = 5;

  // bit set means that local port is the network variant, clear means serial
  localparam logic [NUM_LOCAL-1:0] NETWORK_VARIANT_MASK = 2'h2;

  // ==========================================================================
  // values after reset
  localparam logic [2:0]        SENSE_SYNC_RST = 3'h0;
  localparam logic [QPTR_W-1:0] QPTR_RST       = 4'h0;
  localparam logic [QCNT_W-1:0] QCNT_RST       = 5'h00;

  // ==========================================================================
  // request operations
  typedef enum logic [1:0] {
    ICS_OP_CONNECT = 2'h0,
    ICS_OP_LISTEN  = 2'h1,
    ICS_OP_SEND    = 2'h2,
    ICS_OP_NONE    = 2'h3
  } ics_op_t;

  // response codes
  typedef enum logic [3:0] {
    ICS_RSP_GOOD           = 4'h0,
    ICS_RSP_INVALID_LOCAL  = 4'h1,
    ICS_RSP_LOCAL_IN_USE   = 4'h2,
    ICS_RSP_INVALID_REMOTE = 4'h3,
    ICS_RSP_CONN_REFUSED   = 4'h4,
    ICS_RSP_NO_PHYSICAL    = 4'h5,
    ICS_RSP_INVALID_CONN   = 4'h6,
    ICS_RSP_INVALID_BUFFER = 4'h7,
    ICS_RSP_OUT_OF_RES     = 4'h8
  } ics_rsp_t;

  // connection table entry state
  typedef enum logic [1:0] {
    ICS_ENT_FREE      = 2'h0,
    ICS_ENT_LISTENING = 2'h1,
    ICS_ENT_CONNECTED = 2'h2
  } ics_ent_t;

endpackage

// File: verif/ics_conn_service_chk.sv
// assertion checker for the interconnect connection service
`timescale 1ns/1ps

module ics_conn_service_chk (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // request side
  input  wire logic       i_sense,
  input  wire logic       i_req_valid,
  input  wire logic [1:0] i_req_op,
  input  wire logic [1:0] i_req_local_port,
  // answers and stream
  input  wire logic       o_rsp_valid,
  input  wire logic [3:0] o_rsp_code,
  input  wire logic [1:0] o_rsp_conn,
  input  wire logic       o_connected,
  input  wire logic [1:0] o_connected_conn,
  input  wire logic       o_tx_valid,
  input  wire logic [7:0] o_tx_data,
  input  wire logic [1:0] o_tx_conn,
  input  wire logic       i_tx_ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ==========================================================================
  // helper logic
  logic take;
  logic cl_req;
  logic seen_req_reg;
  assign take   = i_req_valid && (i_req_op != 2'h3);
  assign cl_req = i_req_valid && (i_req_op <= 2'h1);

  // remembers that a connect or listen was ever taken
  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      seen_req_reg <= 1'b0;
    else if (cl_req)
      seen_req_reg <= 1'b1;
  end

  // five edges low covers the whole sense filter, hold path included
  sequence s_sense_low;
    (!i_sense) [*5];
  endsequence
  sequence s_serial_ok;
    (cl_req && i_req_local_port == 2'h0) ##1 (o_rsp_code == 4'h0);
  endsequence

  // ==========================================================================
  // assertions
  AST_RSP_TAKEN: assert property (take |=> o_rsp_valid)
    else $error("response strobe missing after a request");
  AST_RSP_PULSE: assert property (!take |=> !o_rsp_valid)
    else $error("response strobe without a request");
  AST_BAD_LOCAL: assert property (
    cl_req && i_req_local_port[1] |=> o_rsp_code == 4'h1)
    else $error("bad local port not reported");
  AST_NO_PHYS: assert property (
    s_sense_low ##0 (cl_req && !i_req_local_port[1]) |=> o_rsp_code == 4'h5)
    else $error("request passed with sense low");
  AST_SERIAL_UP: assert property (
    s_serial_ok |-> o_connected && (o_connected_conn == o_rsp_conn))
    else $error("serial port not connected at once");
  AST_CONN_CAUSE: assert property (o_connected |-> seen_req_reg)
    else $error("connected without connect or listen");
  AST_TX_HOLD: assert property (
    o_tx_valid && !i_tx_ready |=>
      o_tx_valid && $stable(o_tx_data) && $stable(o_tx_conn))
    else $error("held character changed or vanished");
  AST_TX_START: assert property (
    $rose(o_tx_valid) |-> o_rsp_valid && (o_rsp_code == 4'h0))
    else $error("stream started without an accepted send");
endmodule

bind ics_conn_service ics_conn_service_chk i_ics_conn_service_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sense(i_sense),
  .i_req_valid(i_req_valid), .i_req_op(i_req_op),
  .i_req_local_port(i_req_local_port), .o_rsp_valid(o_rsp_valid),
  .o_rsp_code(o_rsp_code), .o_rsp_conn(o_rsp_conn),
  .o_connected(o_connected), .o_connected_conn(o_connected_conn),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_conn(o_tx_conn),
  .i_tx_ready(i_tx_ready));

// File: verif/ics_link_model.sv
// behavioural model of the link and the remote interconnect port
`timescale 1ns/1ps

module ics_link_model (
  // clock
  input  wire logic       i_clk,
  // scenario control
  input  wire logic       i_stall,
  input  wire logic       i_slow,
  input  wire logic [3:0] i_listen_mask,
  input  wire logic       i_kick,
  input  wire logic [1:0] i_kick_port,
  // toward the port under test
  output logic [3:0]      o_remote_listen,
  output logic            o_remote_conn_valid,
  output logic [1:0]      o_remote_conn_port,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic [1:0] i_tx_conn,
  output logic            o_tx_ready
);
  logic [9:0] got_q[$];  // characters taken off the link, oldest first

  initial begin
    o_remote_listen = 4'h0;
    o_remote_conn_valid = 1'b0;
    o_remote_conn_port = 2'h0;
    o_tx_ready = 1'b0;
  end

  // remote listens, arrivals and the link's pace
  always @(posedge i_clk) begin
    o_remote_listen <= i_listen_mask;
    o_remote_conn_valid <= i_kick;
    // port lines show noise while no arrival is signalled
    o_remote_conn_port <= i_kick ? i_kick_port : ~o_remote_conn_port;
    // slow mode takes every other cycle to exercise the hold path
    o_tx_ready <= !i_stall && (!i_slow || !o_tx_ready);
    if (i_tx_valid && o_tx_ready)
      got_q.push_back({i_tx_conn, i_tx_data});
  end
endmodule

// File: verif/tb.sv
// self-checking bench for the interconnect connection service
`timescale 1ns/1ps

module tb;
  logic        i_clk, i_rst_n, i_sense, i_req_valid, i_req_buf_valid;
  logic [1:0]  i_req_op, i_req_requester, i_req_local_port, i_req_conn;
  logic [2:0]  i_req_remote_port, i_req_count;
  logic [31:0] i_req_data;
  logic        o_rsp_valid, o_connected, o_tx_valid, tx_ready, rc_valid;
  logic [3:0]  o_rsp_code, rlisten, listen_mask;
  logic [1:0]  o_rsp_conn, o_connected_conn, o_tx_conn, rc_port, kick_port;
  logic [7:0]  o_tx_data;
  logic        stall, slow, kick;
  logic [9:0]  exp_q[$];
  int          fails, cmp_count, n;

  ics_conn_service i_ics_conn_service (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sense(i_sense),
    .i_req_valid(i_req_valid), .i_req_op(i_req_op),
    .i_req_requester(i_req_requester), .i_req_local_port(i_req_local_port),
    .i_req_remote_port(i_req_remote_port), .i_req_conn(i_req_conn),
    .i_req_buf_valid(i_req_buf_valid), .i_req_count(i_req_count),
    .i_req_data(i_req_data), .o_rsp_valid(o_rsp_valid),
    .o_rsp_code(o_rsp_code), .o_rsp_conn(o_rsp_conn),
    .o_connected(o_connected), .o_connected_conn(o_connected_conn),
    .i_remote_listen(rlisten), .i_remote_conn_valid(rc_valid),
    .i_remote_conn_port(rc_port), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_conn(o_tx_conn), .i_tx_ready(tx_ready));

  ics_link_model i_ics_link_model (
    .i_clk(i_clk), .i_stall(stall), .i_slow(slow),
    .i_listen_mask(listen_mask), .i_kick(kick), .i_kick_port(kick_port),
    .o_remote_listen(rlisten), .o_remote_conn_valid(rc_valid),
    .o_remote_conn_port(rc_port), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .i_tx_conn(o_tx_conn), .o_tx_ready(tx_ready));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // one request held for one edge; the strobe stands right after that edge
  task automatic issue(input logic [1:0] op, rq, lp, cn,
                       input logic [2:0] rp, cnt, input logic bv,
                       input logic [31:0] dat, input logic [3:0] exp);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req_op <= op;
    i_req_requester <= rq;
    i_req_local_port <= lp;
    i_req_conn <= cn;
    i_req_remote_port <= rp;
    i_req_count <= cnt;
    i_req_buf_valid <= bv;
    i_req_data <= dat;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    #1;
    check(o_rsp_valid, 1'b1);
    check(o_rsp_code, exp);
  endtask

  task automatic cl(input logic [1:0] op, rq, lp, input logic [2:0] rp,
                    input logic [3:0] exp, input logic [1:0] econn);
    issue(op, rq, lp, 2'h0, rp, 3'h0, 1'b0, 32'h0, exp);
    if (exp == 4'h0)
      check(o_rsp_conn, econn);
  endtask

  // an accepted send adds its lanes to the expected stream
  task automatic snd(input logic [1:0] cn, input logic bv,
                     input logic [2:0] cnt, input logic [31:0] dat,
                     input logic [3:0] exp);
    issue(2'h2, 2'h0, 2'h0, cn, 3'h0, cnt, bv, dat, exp);
    if (exp == 4'h0)
      for (int k = 0; k < cnt; k++)
        exp_q.push_back({cn, dat[k*8 +: 8]});
  endtask

  task automatic sc_sense();
    cl(2'h0, 2'h0, 2'h0, 3'h0, 4'h5, 2'h0);
    cl(2'h1, 2'h0, 2'h1, 3'h0, 4'h5, 2'h0);
    cl(2'h0, 2'h1, 2'h1, 3'h1, 4'h5, 2'h0);
    @(posedge i_clk);
    i_sense <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int o = 0; o < 2; o++)
      for (int p = 2; p < 4; p++)
        cl(o[1:0], 2'h0, p[1:0], 3'h0, 4'h1, 2'h0);
  endtask

  task automatic sc_connect();
    cl(2'h0, 2'h0, 2'h0, 3'h7, 4'h0, 2'h0);
    check(o_connected_conn, 2'h0);
    cl(2'h1, 2'h1, 2'h0, 3'h0, 4'h2, 2'h0);
    cl(2'h1, 2'h0, 2'h1, 3'h0, 4'h2, 2'h0);
    cl(2'h1, 2'h1, 2'h1, 3'h0, 4'h0, 2'h1);
    check(o_connected, 1'b0);
    cl(2'h1, 2'h2, 2'h1, 3'h0, 4'h0, 2'h2);
    cl(2'h0, 2'h3, 2'h1, 3'h5, 4'h3, 2'h0);
    cl(2'h0, 2'h3, 2'h1, 3'h2, 4'h4, 2'h0);
    // the remote end arrives on the network port
    @(posedge i_clk);
    kick <= 1'b1;
    kick_port <= 2'h1;
    @(posedge i_clk);
    kick <= 1'b0;
    for (n = 0; n < 6 && !o_connected; n++) begin
      @(posedge i_clk);
      #1;
    end
    check(o_connected_conn, 2'h1);
    if (n == 6) begin
      fails++;
      tally_and_finish();
    end
    cl(2'h0, 2'h3, 2'h1, 3'h1, 4'h0, 2'h3);
  endtask

  task automatic sc_send_errors();
    snd(2'h2, 1'b1, 3'h1, 32'h0, 4'h6);
    snd(2'h0, 1'b0, 3'h1, 32'h0, 4'h7);
    snd(2'h0, 1'b1, 3'h0, 32'h0, 4'h7);
    snd(2'h0, 1'b1, 3'h5, 32'h0, 4'h7);
    check(o_tx_valid, 1'b0);
  endtask

  // fill the queue while the link stalls, then drain at half rate
  task automatic sc_fill_drain();
    snd(2'h0, 1'b1, 3'h3, 32'hA3A2A1A0, 4'h0);
    snd(2'h1, 1'b1, 3'h4, 32'hB3B2B1B0, 4'h0);
    snd(2'h3, 1'b1, 3'h4, 32'hC3C2C1C0, 4'h0);
    snd(2'h0, 1'b1, 3'h4, 32'hD3D2D1D0, 4'h0);
    snd(2'h1, 1'b1, 3'h2, 32'hE1E0E1E0, 4'h8);
    snd(2'h1, 1'b1, 3'h1, 32'h000000F0, 4'h0);
    check(o_tx_valid, 1'b1);
    check(i_ics_link_model.got_q.size(), 0);
    @(posedge i_clk);
    stall <= 1'b0;
    slow <= 1'b1;
    for (n = 0; n < 200 && i_ics_link_model.got_q.size() < 16; n++)
      @(posedge i_clk);
    if (n == 200) begin
      fails++;
      tally_and_finish();
    end
    repeat (3) @(posedge i_clk);
    check(i_ics_link_model.got_q.size(), exp_q.size());
    foreach (exp_q[k])
      check(i_ics_link_model.got_q[k], exp_q[k]);
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_sense = 1'b0;
    i_req_valid = 1'b0;
    i_req_op = 2'h3;
    {i_req_requester, i_req_local_port, i_req_conn} = 6'h00;
    {i_req_remote_port, i_req_count, i_req_buf_valid} = 7'h00;
    i_req_data = 32'h0;
    {stall, slow, kick, kick_port} = 5'h10;
    listen_mask = 4'h2;
    fails = 0;
    cmp_count = 0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    sc_sense();
    sc_connect();
    sc_send_errors();
    sc_fill_drain();
    tally_and_finish();
  end
endmodule

// File: verilog/ics_conn_service.sv
// connection management and transmit queue of an interconnect port
`timescale 1ns/1ps

module ics_conn_service (
  // clock and reset
  input  wire logic                                   i_clk,
  input  wire logic                                   i_rst_n,
  // presence sense pin
  input  wire logic                                   i_sense,
  // request from the upper link layer
  input  wire logic                                   i_req_valid,
  input  wire logic [1:0]                             i_req_op,
  input  wire logic [ics_pkg::REQ_W-1:0]              i_req_requester,
  input  wire logic [ics_pkg::LPORT_W-1:0]            i_req_local_port,
  input  wire logic [ics_pkg::RPORT_W-1:0]            i_req_remote_port,
  input  wire logic [ics_pkg::CONN_W-1:0]             i_req_conn,
  input  wire logic                                   i_req_buf_valid,
  input  wire logic [ics_pkg::CNT_W-1:0]              i_req_count,
  input  wire logic [ics_pkg::MAX_CHARS*ics_pkg::CHAR_W-1:0] i_req_data,
  // response to the upper link layer
  output logic                                        o_rsp_valid,
  output logic [3:0]                                  o_rsp_code,
  output logic [ics_pkg::CONN_W-1:0]                  o_rsp_conn,
  // connected indication
  output logic                                        o_connected,
  output logic [ics_pkg::CONN_W-1:0]                  o_connected_conn,
  // remote side of the network port
  input  wire logic [ics_pkg::NUM_REMOTE-1:0]         i_remote_listen,
  input  wire logic                                   i_remote_conn_valid,
  input  wire logic [ics_pkg::LPORT_W-1:0]            i_remote_conn_port,
  // character stream toward the link
  output logic                                        o_tx_valid,
  output logic [ics_pkg::CHAR_W-1:0]                  o_tx_data,
  output logic [ics_pkg::CONN_W-1:0]                  o_tx_conn,
  input  wire logic                                   i_tx_ready
);

  // ==========================================================================
  // sense synchroniser
  logic [2:0] sense_sync_reg;
  logic       sense_reg;

  // three stages; the filtered level moves only when the last two agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sense_sync_reg <= ics_pkg::SENSE_SYNC_RST;
    end else begin
      sense_sync_reg <= {sense_sync_reg[1:0], i_sense};
    end
  end

  // filtered sense, low after reset so no connect passes before it settles
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sense_reg <= 1'b0;
    end else if (sense_sync_reg[1] == sense_sync_reg[2]) begin
      sense_reg <= sense_sync_reg[2];
    end
  end

  // ==========================================================================
  // connection table
  ics_pkg::ics_ent_t               ent_state_reg [ics_pkg::NUM_CONN];
  logic [ics_pkg::REQ_W-1:0]       ent_req_reg   [ics_pkg::NUM_CONN];
  logic [ics_pkg::LPORT_W-1:0]     ent_port_reg  [ics_pkg::NUM_CONN];

  logic                            free_found;
  logic [ics_pkg::CONN_W-1:0]      free_idx;
  logic                            req_busy;
  logic                            port_busy;
  logic                            lis_found;
  logic [ics_pkg::CONN_W-1:0]      lis_idx;

  // scans of the table for the decision below
  always_comb begin
    free_found = 1'b0;
    free_idx   = '0;
    req_busy   = 1'b0;
    port_busy  = 1'b0;
    lis_found  = 1'b0;
    lis_idx    = '0;
    for (int i = ics_pkg::NUM_CONN - 1; i >= 0; i--) begin
      if (ent_state_reg[i] == ics_pkg::ICS_ENT_FREE) begin
        free_found = 1'b1;
        free_idx   = i[ics_pkg::CONN_W-1:0];
      end else begin
        if (ent_req_reg[i] == i_req_requester) begin
          req_busy = 1'b1;
        end
        if (ent_port_reg[i] == i_req_local_port) begin
          port_busy = 1'b1;
        end
      end
      if (ent_state_reg[i] == ics_pkg::ICS_ENT_LISTENING &&
          ent_port_reg[i] == i_remote_conn_port) begin
        lis_found = 1'b1;
        lis_idx   = i[ics_pkg::CONN_W-1:0];
      end
    end
  end

  // ==========================================================================
  // request decode
  logic                            lport_ok;
  logic                            is_network;
  logic                            rport_ok;
  logic                            rport_listens;
  logic                            is_connect;
  logic                            is_listen;
  logic                            is_send;
  logic                            conn_ok;
  logic                            buf_ok;
  logic [ics_pkg::QCNT_W-1:0]      q_free;
  logic [ics_pkg::QCNT_W-1:0]      req_count_w;

  assign is_connect = i_req_valid && (i_req_op == ics_pkg::ICS_OP_CONNECT);
  assign is_listen  = i_req_valid && (i_req_op == ics_pkg::ICS_OP_LISTEN);
  assign is_send    = i_req_valid && (i_req_op == ics_pkg::ICS_OP_SEND);

  // local port validity and variant
  assign lport_ok   = ({1'b0, i_req_local_port} <
                       (ics_pkg::LPORT_W+1)'(ics_pkg::NUM_LOCAL));
  assign is_network = lport_ok &&
                      ics_pkg::NETWORK_VARIANT_MASK[i_req_local_port[0]];

  // remote checks matter only on the network variant
  assign rport_ok      = ({1'b0, i_req_remote_port} <
                          (ics_pkg::RPORT_W+1)'(ics_pkg::NUM_REMOTE));
  assign rport_listens = rport_ok &&
                         i_remote_listen[i_req_remote_port[1:0]];

  // send checks
  assign conn_ok = (ent_state_reg[i_req_conn] ==
                    ics_pkg::ICS_ENT_CONNECTED);
  assign buf_ok  = i_req_buf_valid && (i_req_count != '0) &&
                   (i_req_count <= ics_pkg::CNT_W'(ics_pkg::MAX_CHARS));
  assign req_count_w = {2'h0, i_req_count};

  // ==========================================================================
  // response selection
  ics_pkg::ics_rsp_t               rsp_next;
  logic                            alloc_connect;
  logic                            alloc_listen;
  logic                            push;

  // checks in priority order; only a good result changes any state
  always_comb begin
    rsp_next      = ics_pkg::ICS_RSP_GOOD;
    alloc_connect = 1'b0;
    alloc_listen  = 1'b0;
    push          = 1'b0;
    if (is_connect || is_listen) begin
      if (!lport_ok) begin
        rsp_next = ics_pkg::ICS_RSP_INVALID_LOCAL;
      end else if (!sense_reg) begin
        rsp_next = ics_pkg::ICS_RSP_NO_PHYSICAL;
      end else if (req_busy) begin
        rsp_next = ics_pkg::ICS_RSP_LOCAL_IN_USE;
      end else if (!is_network && port_busy) begin
        rsp_next = ics_pkg::ICS_RSP_LOCAL_IN_USE;
      end else if (is_connect && is_network && !rport_ok) begin
        rsp_next = ics_pkg::ICS_RSP_INVALID_REMOTE;
      end else if (is_connect && is_network && !rport_listens) begin
        rsp_next = ics_pkg::ICS_RSP_CONN_REFUSED;
      end else if (!free_found) begin
        rsp_next = ics_pkg::ICS_RSP_LOCAL_IN_USE;
      end else begin
        // serial: remote argument never looked at above
        alloc_connect = is_connect || !is_network;
        alloc_listen  = is_listen && is_network;
      end
    end else if (is_send) begin
      if (!conn_ok) begin
        rsp_next = ics_pkg::ICS_RSP_INVALID_CONN;
      end else if (!buf_ok) begin
        rsp_next = ics_pkg::ICS_RSP_INVALID_BUFFER;
      end else if (q_free < req_count_w) begin
        rsp_next = ics_pkg::ICS_RSP_OUT_OF_RES;
      end else begin
        push = 1'b1;
      end
    end
  end

  // table update; a remote arrival and a new entry never hit the same slot
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < ics_pkg::NUM_CONN; i++) begin
        ent_state_reg[i] <= ics_pkg::ICS_ENT_FREE;
        ent_req_reg[i]   <= '0;
        ent_port_reg[i]  <= '0;
      end
    end else begin
      if (alloc_connect || alloc_listen) begin
        ent_state_reg[free_idx] <= alloc_connect ?
                                   ics_pkg::ICS_ENT_CONNECTED :
                                   ics_pkg::ICS_ENT_LISTENING;
        ent_req_reg[free_idx]   <= i_req_requester;
        ent_port_reg[free_idx]  <= i_req_local_port;
      end
      if (i_remote_conn_valid && lis_found) begin
        ent_state_reg[lis_idx] <= ics_pkg::ICS_ENT_CONNECTED;
      end
    end
  end

  // response strobe, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
      o_rsp_code  <= ics_pkg::ICS_RSP_GOOD;
      o_rsp_conn  <= '0;
    end else begin
      o_rsp_valid <= is_connect || is_listen || is_send;
      o_rsp_code  <= rsp_next;
      o_rsp_conn  <= is_send ? i_req_conn : free_idx;
    end
  end

  // connected indication; local establish wins over a remote arrival
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_connected      <= 1'b0;
      o_connected_conn <= '0;
    end else if (alloc_connect) begin
      o_connected      <= 1'b1;
      o_connected_conn <= free_idx;
    end else begin
      o_connected      <= i_remote_conn_valid && lis_found;
      o_connected_conn <= lis_idx;
    end
  end

  // ==========================================================================
  // transmit queue
  logic [ics_pkg::CHAR_W-1:0]      q_char_reg [ics_pkg::QUEUE_DEPTH];
  logic [ics_pkg::CONN_W-1:0]      q_conn_reg [ics_pkg::QUEUE_DEPTH];
  logic [ics_pkg::QPTR_W-1:0]      q_wr_reg;
  logic [ics_pkg::QPTR_W-1:0]      q_rd_reg;
  logic [ics_pkg::QCNT_W-1:0]      q_cnt_reg;
  logic                            pop;
  logic [ics_pkg::QCNT_W-1:0]      push_n;

  // free room counts the whole queue, so a partial send is never taken
  assign q_free = ics_pkg::QCNT_W'(ics_pkg::QUEUE_DEPTH) - q_cnt_reg;
  assign push_n = push ? req_count_w : ics_pkg::QCNT_RST;
  assign pop    = o_tx_valid && i_tx_ready;

  // capture lanes in order behind everything already queued
  always_ff @(posedge i_clk) begin
    if (push) begin
      for (int i = 0; i < ics_pkg::MAX_CHARS; i++) begin
        if (i[ics_pkg::CNT_W-1:0] < i_req_count) begin
          q_char_reg[q_wr_reg + i[ics_pkg::QPTR_W-1:0]] <=
            i_req_data[i*ics_pkg::CHAR_W +: ics_pkg::CHAR_W];
          q_conn_reg[q_wr_reg + i[ics_pkg::QPTR_W-1:0]] <= i_req_conn;
        end
      end
    end
  end

  // pointers and fill level; strict fifo keeps sends in order
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q_wr_reg  <= ics_pkg::QPTR_RST;
      q_rd_reg  <= ics_pkg::QPTR_RST;
      q_cnt_reg <= ics_pkg::QCNT_RST;
    end else begin
      q_wr_reg  <= q_wr_reg + push_n[ics_pkg::QPTR_W-1:0];
      q_rd_reg  <= q_rd_reg + {3'h0, pop};
      q_cnt_reg <= q_cnt_reg + push_n - {4'h0, pop};
    end
  end

  // characters are offered from the cycle of the response strobe and leave at the link pace
  assign o_tx_valid = (q_cnt_reg != ics_pkg::QCNT_RST);
  assign o_tx_data  = q_char_reg[q_rd_reg];
  assign o_tx_conn  = q_conn_reg[q_rd_reg];

endmodule
